/* rtl/pbsp_sram_port.sv */
// Pipelined zero-turnaround burst SRAM port with APB control and back-door access
`timescale 1ns/1ps
`default_nettype none
`include "pbsp_params.svh"

// Summary of operation
// - A burst steps only the two low word-address bits, four words from base.
// - Sampling advance-or-load low ends any burst and loads new address and control.
// - While advance-or-load is high the read/write select is ignored.
// - Burst direction is fixed by read/write select at the loading edge.
// - A write starts when read/write select is low at a load.
// - Lane enables of a beat pair with the data arriving two cycles later.
// - Cycle hold high at an edge freezes the burst, pipeline, read-data and beat-counter registers, not the buffer or APB ones.
// - The high chip select has opposite polarity to the two low ones.
// - Selected only with both low selects low and the high select high.
// - Data outputs are released during reset and at the first clock edge after it.
// - Write data is captured two cycles after its address.
module pbsp_sram_port import pbsp_pkg::*; #(
	parameter int ADDR_W = `PBSP_ADDR_W,
	parameter int DATA_W = `PBSP_DATA_W,
	parameter int LANES = `PBSP_LANES,
	parameter int BUF_DEPTH = `PBSP_BUF_DEPTH,
	parameter int APB_AW = `PBSP_APB_AW
) (
	input wire logic pclk,                        // Clock
	input wire logic presetn,                     // Asynchronous reset, active low
	input wire logic psel,                        // APB select
	input wire logic penable,                     // APB enable
	input wire logic pwrite,                      // APB direction
	input wire logic [APB_AW-1:0] paddr,          // APB byte address
	input wire logic [31:0] pwdata,               // APB write data
	output logic [31:0] prdata,                   // APB read data
	output logic pready,                          // APB ready
	output logic pslverr,                         // APB error
	input wire logic [ADDR_W-1:0] address,        // Word address
	input wire logic read_not_write,              // High read, low write
	input wire logic advance_or_load,             // High advance, low load
	input wire logic cycle_hold_n,                // High holds the edge
	input wire logic [LANES-1:0] byte_lane_write_n, // Lane write enables, low active
	input wire logic burst_order_select,          // High interleaved, low linear
	input wire logic chip_select_a_n,             // First low select
	input wire logic chip_select_b_n,             // Second low select
	input wire logic chip_select_high,            // High select
	input wire logic [DATA_W-1:0] sram_data_in,   // Data bus input
	output logic [DATA_W-1:0] sram_data_out,      // Data bus output
	output logic sram_data_oe                     // Data bus drive enable
);
	localparam int LW = DATA_W / LANES;
	localparam int HW = DATA_W - 32;
	localparam int EW = ADDR_W + LANES + DATA_W;

	// ==========================================================================
	// Declarations
	logic [DATA_W-1:0] mem_q [2**ADDR_W];
	logic ctrl_en_q;
	pbsp_mode_t mode_q;
	logic [ADDR_W-1:0] base_q;
	pbsp_beat_t idx_q;
	logic s1_rd_q, s1_wr_q, s2_rd_q, s2_wr_q;
	logic [ADDR_W-1:0] s1_addr_q, s2_addr_q;
	logic [LANES-1:0] s1_lanes_q, s2_lanes_q;
	logic [DATA_W-1:0] dout_q;
	logic oe_q;
	logic [ADDR_W-1:0] mem_addr_q;
	logic [HW-1:0] mem_hi_q;
	logic [31:0] wr_beats_q, rd_beats_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic selected, tick, apb_setup, apb_done, apb_mem_wr;
	logic [ADDR_W-1:0] head_addr;
	logic [LANES-1:0] head_lanes;
	logic [DATA_W-1:0] head_data;
	logic [DATA_W-1:0] rd_word;
	logic [31:0] rd_mux;

	pbsp_stream_if #(.W(EW)) push_if ();
	pbsp_stream_if #(.W(EW)) pop_if ();

	// ==========================================================================
	// Functions
	// Low address bits of a beat in the chosen order
	function automatic pbsp_beat_t beat_low(input pbsp_beat_t b, input pbsp_beat_t i, input logic ilv);
		beat_low = ilv ? (b ^ i) : pbsp_beat_t'(b + i);
	endfunction

	// Lane merge of new data over an old word, lane enables active low
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
		input logic [LANES-1:0] en_n);
		logic [DATA_W-1:0] r;
		r = old;
		for (int l = 0; l < LANES; l++) begin
			if (!en_n[l]) r[l*LW +: LW] = nw[l*LW +: LW];
		end
		merge = r;
	endfunction

	// Register offset decode
	function automatic logic is_mapped(input logic [APB_AW-1:0] a);
		is_mapped = (a == `PBSP_OFS_CTRL) || (a == `PBSP_OFS_STATUS) || (a == `PBSP_OFS_MEM_ADDR) ||
			(a == `PBSP_OFS_MEM_LO) || (a == `PBSP_OFS_MEM_HI) || (a == `PBSP_OFS_WR_BEATS) ||
			(a == `PBSP_OFS_RD_BEATS);
	endfunction

	// ==========================================================================
	// Select decode and edge qualification
	// All three selects must agree, the high one with inverted sense
	assign selected = !chip_select_a_n && !chip_select_b_n && chip_select_high && ctrl_en_q;
	// A held edge, or a full write buffer, leaves the core as it was
	assign tick = !cycle_hold_n && push_if.ready;

	// ==========================================================================
	// Burst control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= PBSP_IDLE;
			base_q <= '0;
			idx_q <= '0;
		end else if (tick) begin
			if (!advance_or_load) begin
				idx_q <= '0;
				if (selected) begin
					base_q <= address;
					mode_q <= read_not_write ? PBSP_READ : PBSP_WRITE;
				end else begin
					mode_q <= PBSP_IDLE;
				end
			end else if (mode_q != PBSP_IDLE) begin
				idx_q <= pbsp_beat_t'(idx_q + 2'h1);
			end
		end
	end

	// ==========================================================================
	// Pipeline stage one: beat address, direction and lane enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_rd_q <= 1'b0;
			s1_wr_q <= 1'b0;
			s1_addr_q <= '0;
			s1_lanes_q <= '1;
		end else if (tick) begin
			s1_lanes_q <= byte_lane_write_n;
			if (!advance_or_load) begin
				s1_rd_q <= selected && read_not_write;
				s1_wr_q <= selected && !read_not_write;
				s1_addr_q <= address;
			end else begin
				// Direction comes from the burst, the select pin is not looked at
				unique case (mode_q)
					PBSP_READ: begin
						s1_rd_q <= 1'b1;
						s1_wr_q <= 1'b0;
					end
					PBSP_WRITE: begin
						s1_rd_q <= 1'b0;
						s1_wr_q <= 1'b1;
					end
					default: begin
						s1_rd_q <= 1'b0;
						s1_wr_q <= 1'b0;
					end
				endcase
				s1_addr_q <= {base_q[ADDR_W-1:2],
					beat_low(base_q[1:0], pbsp_beat_t'(idx_q + 2'h1), burst_order_select)};
			end
		end
	end

	// ==========================================================================
	// Pipeline stage two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s2_rd_q <= 1'b0;
			s2_wr_q <= 1'b0;
			s2_addr_q <= '0;
			s2_lanes_q <= '1;
		end else if (tick) begin
			s2_rd_q <= s1_rd_q;
			s2_wr_q <= s1_wr_q;
			s2_addr_q <= s1_addr_q;
			s2_lanes_q <= s1_lanes_q;
		end
	end

	// ==========================================================================
	// Write capture into the buffer, two cycles after the address
	assign push_if.valid = s2_wr_q && !cycle_hold_n;
	assign push_if.data = {s2_addr_q, s2_lanes_q, sram_data_in};

	pbsp_pair_buf #(.W(EW), .DEPTH(BUF_DEPTH)) u_buf (
		.clk (pclk),
		.rst_n (presetn),
		.in_s (push_if),
		.out_s (pop_if)
	);

	assign {head_addr, head_lanes, head_data} = pop_if.data;
	// The back door owns the array for the cycle of its write
	assign pop_if.ready = !apb_mem_wr;

	// ==========================================================================
	// Array storage: back-door write first, then buffer drain
	always_ff @(posedge pclk) begin
		if (apb_mem_wr) begin
			mem_q[mem_addr_q] <= {mem_hi_q, pwdata};
		end else if (pop_if.valid) begin
			mem_q[head_addr] <= merge(mem_q[head_addr], head_data, head_lanes);
		end
	end

	// Read word, with the buffer head forwarded so a fresh write is seen
	always_comb begin
		rd_word = mem_q[s2_addr_q];
		if (pop_if.valid && (head_addr == s2_addr_q)) rd_word = merge(rd_word, head_data, head_lanes);
	end

	// ==========================================================================
	// Read data and bus drive, two cycles after load or advance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_q <= 1'b0;
			dout_q <= '0;
		end else if (tick) begin
			oe_q <= s2_rd_q;
			if (s2_rd_q) dout_q <= rd_word;
		end
	end

	assign sram_data_out = dout_q;
	assign sram_data_oe = oe_q;

	// ==========================================================================
	// Beat counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_beats_q <= '0;
			rd_beats_q <= '0;
		end else if (tick) begin
			if (s2_wr_q) wr_beats_q <= wr_beats_q + 32'h1;
			if (s2_rd_q) rd_beats_q <= rd_beats_q + 32'h1;
		end
	end

	// ==========================================================================
	// APB slave: one wait-free access phase
	assign apb_setup = psel && !penable;
	assign apb_done = psel && penable && pready_q;
	assign apb_mem_wr = apb_done && pwrite && !pslverr_q && (paddr == `PBSP_OFS_MEM_LO);

	// Read multiplexer
	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			`PBSP_OFS_CTRL: rd_mux[`PBSP_CTRL_EN_BIT] = ctrl_en_q;
			`PBSP_OFS_STATUS: begin
				rd_mux[`PBSP_ST_MODE_LSB +: 3] = mode_q;
				rd_mux[`PBSP_ST_IDX_LSB +: 2] = idx_q;
				rd_mux[`PBSP_ST_OE_BIT] = oe_q;
				rd_mux[`PBSP_ST_FULL_BIT] = !push_if.ready;
			end
			`PBSP_OFS_MEM_ADDR: rd_mux[ADDR_W-1:0] = mem_addr_q;
			`PBSP_OFS_MEM_LO: rd_mux = mem_q[mem_addr_q][31:0];
			`PBSP_OFS_MEM_HI: rd_mux[HW-1:0] = mem_q[mem_addr_q][DATA_W-1:32];
			`PBSP_OFS_WR_BEATS: rd_mux = wr_beats_q;
			`PBSP_OFS_RD_BEATS: rd_mux = rd_beats_q;
			default: rd_mux = 32'h0;
		endcase
	end

	// Answer phase: ready, error and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= apb_setup;
			pslverr_q <= apb_setup && !is_mapped(paddr);
			if (apb_setup && !pwrite) prdata_q <= rd_mux;
			else if (apb_done) prdata_q <= 32'h0;
		end
	end

	// Software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_q <= `PBSP_CTRL_RST;
			mem_addr_q <= '0;
			mem_hi_q <= '0;
		end else if (apb_done && pwrite && !pslverr_q) begin
			case (paddr)
				`PBSP_OFS_CTRL: ctrl_en_q <= pwdata[`PBSP_CTRL_EN_BIT];
				`PBSP_OFS_MEM_ADDR: mem_addr_q <= pwdata[ADDR_W-1:0];
				`PBSP_OFS_MEM_HI: mem_hi_q <= pwdata[HW-1:0];
				default: mem_hi_q <= mem_hi_q;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule

`default_nettype wire

/* include/pbsp_params.svh */
// Constants of the pipelined burst SRAM port: widths, register map, fields and reset values
`ifndef PBSP_PARAMS_SVH
`define PBSP_PARAMS_SVH

// ==========================================================================
// Array and pin widths
`define PBSP_ADDR_W 17
`define PBSP_DATA_W 36
`define PBSP_LANES 4
`define PBSP_BUF_DEPTH 2
`define PBSP_APB_AW 12

// ==========================================================================
// Register offsets (byte addresses)
`define PBSP_OFS_CTRL 12'h000
`define PBSP_OFS_STATUS 12'h004
`define PBSP_OFS_MEM_ADDR 12'h008
`define PBSP_OFS_MEM_LO 12'h00c
`define PBSP_OFS_MEM_HI 12'h010
`define PBSP_OFS_WR_BEATS 12'h014
`define PBSP_OFS_RD_BEATS 12'h018

// ==========================================================================
// Field positions and reset values
`define PBSP_CTRL_EN_BIT 0
`define PBSP_CTRL_RST 1'h1
`define PBSP_ST_MODE_LSB 0
`define PBSP_ST_IDX_LSB 4
`define PBSP_ST_OE_BIT 6
`define PBSP_ST_FULL_BIT 7

`endif

/* include/pbsp_pkg.sv */
// Types shared by the pipelined burst SRAM port
package pbsp_pkg;

	// Burst direction held between loads, one-hot
	typedef enum logic [2:0] {
		PBSP_IDLE = 3'h1,
		PBSP_READ = 3'h2,
		PBSP_WRITE = 3'h4
	} pbsp_mode_t;

	typedef logic [1:0] pbsp_beat_t;

endpackage

/* include/pbsp_stream_if.sv */
// Valid/ready stream carrying write beats between the port core and its buffer
`timescale 1ns/1ps
`default_nettype none

interface pbsp_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* rtl/pbsp_pair_buf.sv */
// Small circular valid/ready buffer for captured write beats
`timescale 1ns/1ps
`default_nettype none

module pbsp_pair_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,           // Clock
	input wire logic rst_n,         // Asynchronous reset, active low
	pbsp_stream_if.snk in_s,        // Filling side
	pbsp_stream_if.src out_s        // Draining side
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] ent_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] cnt_q;
	logic push;
	logic pop;

	// Pointer step with wrap at the configured depth
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	// Honest full and empty flags
	assign in_s.ready = (cnt_q != (PW + 1)'(DEPTH));
	assign out_s.valid = (cnt_q != '0);
	assign out_s.data = ent_q[rd_q];
	assign push = in_s.valid & in_s.ready;
	assign pop = out_s.valid & out_s.ready;

	// Pointers and fill count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= step(wr_q);
			if (pop) rd_q <= step(rd_q);
			if (push && !pop) cnt_q <= (PW + 1)'(cnt_q + 1'b1);
			else if (pop && !push) cnt_q <= (PW + 1)'(cnt_q - 1'b1);
		end
	end

	// Entry storage
	always_ff @(posedge clk) begin
		if (push) ent_q[wr_q] <= in_s.data;
	end
endmodule

`default_nettype wire

/* verif/pbsp_sram_port_assertions.sv */
// Pin-level checker of the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
`include "pbsp_params.svh"
module pbsp_port_chk #(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 36,
	parameter int LANES = 4,
	parameter int APB_AW = 12
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // APB
	input wire logic penable, // APB
	input wire logic pwrite, // APB
	input wire logic [APB_AW-1:0] paddr, // APB
	input wire logic [31:0] pwdata, // APB
	input wire logic [31:0] prdata, // APB
	input wire logic pready, // APB
	input wire logic pslverr, // APB
	input wire logic [ADDR_W-1:0] address, // Pin
	input wire logic read_not_write, // Pin
	input wire logic advance_or_load, // Pin
	input wire logic cycle_hold_n, // Pin
	input wire logic [LANES-1:0] byte_lane_write_n, // Pin
	input wire logic burst_order_select, // Pin
	input wire logic chip_select_a_n, // Pin
	input wire logic chip_select_b_n, // Pin
	input wire logic chip_select_high, // Pin
	input wire logic [DATA_W-1:0] sram_data_in, // Pin
	input wire logic [DATA_W-1:0] sram_data_out, // Pin
	input wire logic sram_data_oe // Pin
);
	// ==========
	// Selection and unheld edges
	logic en_q;
	// Software enable mirrored from completed control writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= `PBSP_CTRL_RST;
		end else if (psel && penable && pready && pwrite && !pslverr && paddr == `PBSP_OFS_CTRL) begin
			en_q <= pwdata[`PBSP_CTRL_EN_BIT];
		end
	end
	wire logic sel = en_q && !chip_select_a_n && !chip_select_b_n && chip_select_high;
	wire logic tick = !cycle_hold_n;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_load(logic rd);
		!advance_or_load && sel && tick && read_not_write == rd;
	endsequence
	property p_read_drive;
		s_load(1'b1) ##1 tick ##1 tick |=> sram_data_oe;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");
	property p_write_release;
		s_load(1'b0) ##1 tick ##1 tick |=> !sram_data_oe;
	endproperty
	a_write_release: assert property (p_write_release) else $error("bus kept after write");
	property p_desel;
		!advance_or_load && !sel && tick ##1 tick ##1 tick |=> !sram_data_oe;
	endproperty
	a_desel: assert property (p_desel) else $error("bus kept after deselect");
	property p_adv_rw;
		s_load(1'b1) ##1 (advance_or_load && !read_not_write && tick) ##1 tick ##1 tick |=> sram_data_oe;
	endproperty
	a_adv_rw: assert property (p_adv_rw) else $error("advance changed direction");
	property p_hold;
		cycle_hold_n |=> $stable(sram_data_oe) && $stable(sram_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("held edge changed outputs");
	property p_first_edge;
		$rose(presetn) |-> !sram_data_oe && !pready;
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("bus driven at first edge");
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
	c_burst: cover property (s_load(1'b1) ##1 advance_or_load [*4]);
	c_hold: cover property (cycle_hold_n ##1 tick);
	c_err: cover property (pready && pslverr);
endmodule
bind pbsp_sram_port pbsp_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES), .APB_AW(APB_AW)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .address,
	.read_not_write, .advance_or_load, .cycle_hold_n, .byte_lane_write_n, .burst_order_select,
	.chip_select_a_n, .chip_select_b_n, .chip_select_high, .sram_data_in, .sram_data_out, .sram_data_oe);
`default_nettype wire

/* verif/pbsp_host_model.sv */
// Host controller model driving the port's pins
`timescale 1ns/1ps
`default_nettype none
module pbsp_host_model #(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 36,
	parameter int LANES = 4
) (
	input wire logic clk, // Clock
	output logic [ADDR_W-1:0] address, // Pin
	output logic read_not_write, // Pin
	output logic advance_or_load, // Pin
	output logic cycle_hold_n, // Pin
	output logic [LANES-1:0] byte_lane_write_n, // Pin
	output logic burst_order_select, // Pin
	output logic chip_select_a_n, // Pin
	output logic chip_select_b_n, // Pin
	output logic chip_select_high, // Pin
	output logic [DATA_W-1:0] sram_data_in // Pin
);
	logic [DATA_W:0] due_q[2];
	logic wr_q;
	// Deselected loads until the bench drives
	initial begin
		{address, read_not_write, advance_or_load, cycle_hold_n, byte_lane_write_n} = '0;
		{burst_order_select, chip_select_a_n, chip_select_b_n, chip_select_high, sram_data_in} = '0;
		due_q = '{default: '0};
		wr_q = 1'b0;
	end
	// One cycle of pins; a write beat's data follows two unheld edges later
	task automatic drive(input logic ld, rnw, hold, ord, input logic [2:0] sel,
			input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw, input logic [DATA_W-1:0] wd);
		address <= a;
		read_not_write <= rnw;
		advance_or_load <= !ld;
		cycle_hold_n <= hold;
		byte_lane_write_n <= bw;
		burst_order_select <= ord;
		{chip_select_a_n, chip_select_b_n, chip_select_high} <= sel;
		sram_data_in <= due_q[1][DATA_W] ? due_q[1][DATA_W-1:0] : ~sram_data_in;
		if (!hold) begin
			if (ld) wr_q = sel == 3'b001 && !rnw;
			due_q[1] = due_q[0];
			due_q[0] = {wr_q, wd};
		end
	endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench of the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
`include "pbsp_params.svh"
module tb;
	localparam logic [2:0] sel_on = 3'b001;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, sram_data_oe, read_not_write, advance_or_load, cycle_hold_n, burst_order_select;
	logic chip_select_a_n, chip_select_b_n, chip_select_high, ord, exp_oe;
	logic [16:0] address, base, b, op_a[2];
	logic [3:0] byte_lane_write_n, op_bw[2];
	logic [35:0] sram_data_in, sram_data_out, exp_d, op_d[2];
	logic [35:0] mem [int];
	logic [2:0] desel[3] = '{3'b101, 3'b011, 3'b000};
	int op_k[2] = '{0, 0};
	int mismatches = 0;
	int total_checks = 0;
	int cyc = 0;
	int seed = 32'h8e34;
	int mode = 0;
	int idx = 0;
	int n_wr = 0;
	int n_rd = 0;
	logic en = 1'b1;
	// ==========
	// Design and host model
	pbsp_sram_port u_pbsp_sram_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .address, .read_not_write, .advance_or_load, .cycle_hold_n, .byte_lane_write_n, .burst_order_select,
		.chip_select_a_n, .chip_select_b_n, .chip_select_high, .sram_data_in, .sram_data_out, .sram_data_oe);
	pbsp_host_model u_pbsp_host_model (.clk(pclk), .address, .read_not_write, .advance_or_load, .cycle_hold_n,
		.byte_lane_write_n, .burst_order_select, .chip_select_a_n, .chip_select_b_n, .chip_select_high, .sram_data_in);
	initial begin
		forever #2 pclk = ~pclk;
	end
	// Cycle limit cuts a hang short
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One core cycle: drive pins, compare last edge's result, advance the model
	task automatic step(input logic ld, rnw, input logic [2:0] sel, input logic [16:0] a, input logic [3:0] bw,
			input logic hold = 1'b0);
		logic [35:0] wd;
		wd = {4'($random(seed)), 32'($random(seed))};
		u_pbsp_host_model.drive(ld, rnw, hold, ord, sel, a, bw, wd);
		@(posedge pclk);
		check(36'(sram_data_oe), 36'(exp_oe));
		if (exp_oe) check(sram_data_out, exp_d);
		if (!hold) begin
			if (op_k[1] == 2) begin
				for (int l = 0; l < 4; l++) begin
					if (!op_bw[1][l]) mem[op_a[1]][l*9+:9] = op_d[1][l*9+:9];
				end
			end
			exp_oe = op_k[1] == 1;
			if (exp_oe) exp_d = mem[op_a[1]];
			// Beats that reach the data bus stage, as the beat counters see them
			if (op_k[1] == 2) n_wr++;
			if (exp_oe) n_rd++;
			if (ld) begin
				mode = (sel == sel_on && en) ? (rnw ? 1 : 2) : 0;
				base = a;
				idx = 0;
			end else if (mode != 0) begin
				idx = (idx + 1) % 4;
			end
			op_k[1] = op_k[0];
			op_a[1] = op_a[0];
			op_bw[1] = op_bw[0];
			op_d[1] = op_d[0];
			op_k[0] = mode;
			op_a[0] = {base[16:2], ord ? base[1:0] ^ 2'(idx) : base[1:0] + 2'(idx)};
			op_bw[0] = bw;
			op_d[0] = wd;
		end
	endtask
	task automatic idle(input int n);
		repeat (n) step(1'b1, 1'b1, 3'b100, 17'h0, 4'hf);
	endtask
	// One APB transfer, held until ready is sampled
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wdat, exp, input logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wdat;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		if (!wr) check(36'(prdata), 36'(exp));
		check(36'(pslverr), 36'(err));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ==========
	// Main sequence
	initial begin
		ord = 1'b0;
		exp_oe = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `PBSP_OFS_CTRL, 32'h0, 32'h1, 1'b0);
		apb(1'b0, `PBSP_OFS_STATUS, 32'h0, 32'h1, 1'b0);
		apb(1'b1, 12'h020, 32'h5, 32'h0, 1'b1);
		apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
		for (int o = 0; o < 2; o++) begin
			ord = o[0];
			b = 17'($random(seed));
			step(1'b1, 1'b0, sel_on, b, 4'h0);
			repeat (3) step(1'b0, 1'b1, sel_on, 17'h0, 4'h0);
			step(1'b1, 1'b0, sel_on, b, 4'($random(seed)));
			step(1'b1, 1'b1, sel_on, b, 4'hf);
			for (int i = 0; i < 6; i++) step(1'b0, 1'b0, sel_on, 17'h0, 4'hf, i == 2);
			foreach (desel[j]) step(1'b1, 1'b1, desel[j], b, 4'hf);
			idle(3);
			apb(1'b1, `PBSP_OFS_MEM_ADDR, 32'(b), 32'h0, 1'b0);
			apb(1'b0, `PBSP_OFS_MEM_LO, 32'h0, mem[b][31:0], 1'b0);
			apb(1'b0, `PBSP_OFS_MEM_HI, 32'h0, 32'(mem[b][35:32]), 1'b0);
			apb(1'b1, `PBSP_OFS_MEM_HI, 32'(o + 3), 32'h0, 1'b0);
			mem[b] = {4'(o + 3), 32'($random(seed))};
			apb(1'b1, `PBSP_OFS_MEM_LO, mem[b][31:0], 32'h0, 1'b0);
			step(1'b1, 1'b1, sel_on, b, 4'hf);
			idle(3);
		end
		// Software disable makes a selected read act deselected
		apb(1'b1, `PBSP_OFS_CTRL, 32'h0, 32'h0, 1'b0);
		en = 1'b0;
		step(1'b1, 1'b1, sel_on, b, 4'hf);
		idle(3);
		apb(1'b0, `PBSP_OFS_CTRL, 32'h0, 32'h0, 1'b0);
		apb(1'b0, `PBSP_OFS_WR_BEATS, 32'h0, 32'(n_wr), 1'b0);
		apb(1'b0, `PBSP_OFS_RD_BEATS, 32'h0, 32'(n_rd), 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
